// *** logic/eeprom_rd_consts.svh ***
// timing counts, byte codes and sizes shared by both ends of the serial read link
`ifndef EEPROM_RD_CONSTS_SVH
`define EEPROM_RD_CONSTS_SVH
`define DEV_TYPE_MEM 4'hA
`define DEV_TYPE_QUERY 4'h6
`define QUAD_ID_0 3'h1
`define QUAD_ID_1 3'h4
`define QUAD_ID_2 3'h5
`define QUAD_ID_3 3'h0
`define BIT_ACK_SLOT 4'h8
`define BIT_LAST_TX 4'h7
`define MEM_WORDS 512
`define RD_FIFO_WIDTH 8
`define RD_FIFO_DEPTH 32
`define CORE_CLK_MHZ 100
`define SCL_QTR_NS 40
`define SCL_QTR_CYC ((`SCL_QTR_NS * `CORE_CLK_MHZ + 999) / 1000)
`endif

// *** logic/eeprom_rd_pkg.sv ***
// types and quadrant code helpers for the serial read link
`include "eeprom_rd_consts.svh"
package eeprom_rd_pkg;
    typedef enum logic [2:0] {
        DEV_IDLE = 3'h0,
        DEV_RX = 3'h1,
        DEV_ACK = 3'h3,
        DEV_TX = 3'h2,
        DEV_RACK = 3'h6,
        DEV_WAIT = 3'h7
    } dev_state_t;

    typedef enum logic [2:0] {
        MST_IDLE = 3'h0,
        MST_START = 3'h1,
        MST_CTRLW = 3'h3,
        MST_WORD = 3'h2,
        MST_RSTART = 3'h6,
        MST_CTRLR = 3'h7,
        MST_DATA = 3'h5,
        MST_STOP = 3'h4
    } mst_step_t;

    typedef enum logic [1:0] {
        RD_CURRENT = 2'h0,
        RD_RANDOM = 2'h1,
        RD_QUERY = 2'h2
    } rd_kind_t;

    function automatic logic [2:0] quad_enc(input logic [1:0] q);
        case (q)
            2'h0: quad_enc = `QUAD_ID_0;
            2'h1: quad_enc = `QUAD_ID_1;
            2'h2: quad_enc = `QUAD_ID_2;
            default: quad_enc = `QUAD_ID_3;
        endcase
    endfunction

    // bit 2 flags a valid code
    function automatic logic [2:0] quad_dec(input logic [2:0] m);
        case (m)
            `QUAD_ID_0: quad_dec = 3'h4;
            `QUAD_ID_1: quad_dec = 3'h5;
            `QUAD_ID_2: quad_dec = 3'h6;
            `QUAD_ID_3: quad_dec = 3'h7;
            default: quad_dec = 3'h0;
        endcase
    endfunction
endpackage

// *** logic/eeprom_rd_if.sv ***
// two-wire link between the bus master and the memory device
`timescale 1ns/100ps
interface eeprom_rd_if;
    logic scl;
    logic sda;
    logic mst_scl_o;
    logic mst_sda_o;
    logic mst_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;

    // open-drain data: any enabled low driver pulls the wire low
    assign scl = mst_scl_o;
    assign sda = !((mst_sda_oe && !mst_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport master(input sda, output mst_scl_o, output mst_sda_o, output mst_sda_oe);
endinterface

// *** logic/rd_fifo.sv ***
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module rd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] buf_r [0:DEPTH-1];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic full_r;
    logic valid_r;
    logic push;
    logic pop;

    assign push = in_valid_i && !full_r;
    assign pop = valid_r && out_ready_i;
    assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign in_ready_o = !full_r;
    assign out_valid_o = valid_r;
    assign out_data_o = buf_r[rp_r];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            buf_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            wp_r <= wp_r + AW'(push);
            rp_r <= rp_r + AW'(pop);
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == (AW+1)'(DEPTH));
            valid_r <= (cnt_nxt != '0);
        end
    end
endmodule

// *** logic/eeprom_dev.sv ***
// memory device end: decodes the two-wire link and returns read data
//
// What this block does
// - master opens reads with start, 1010, straps, read
// - acknowledge matching address byte after its eighth bit
// - current read: acknowledge, then send byte at counter
// - counter holds last accessed plus one, persists
// - wrap at end of half to its zero
// - master nack then stop ends read; release data
// - random read preloads counter by dummy write
// - repeated start, read address, then addressed byte out
// - keep sending bytes while master acknowledges each
// - master selects intended half before reading
// - status query ignores strap pins
// - query byte 0110, quadrant code, read bit
// - query acked only if unprotected; later bytes nacked
// - half select picks quadrant pair, addresses 00h-FFh
`timescale 1ns/100ps
`include "eeprom_rd_consts.svh"
module eeprom_dev (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    eeprom_rd_if.device bus,
    input wire logic [2:0] strap_i,
    input wire logic half_sel_i,
    input wire logic [3:0] protect_i,
    input wire logic load_en_i,
    input wire logic [8:0] load_addr_i,
    input wire logic [7:0] load_data_i,
    output logic [7:0] addr_count_o,
    output logic busy_o
);
    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= bus.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= bus.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;

    // ************************************************************
    // memory array, filled from the user side
    // ************************************************************
    logic [7:0] mem [0:`MEM_WORDS-1];
    logic [7:0] cnt_r;
    logic [7:0] rd_byte;

    always_ff @(posedge core_clk_i) begin
        if (load_en_i) begin
            mem[load_addr_i] <= load_data_i;
        end
    end

    // half select is the top address bit, so each half spans 00h-FFh
    assign rd_byte = mem[{half_sel_i, cnt_r}];

    // ************************************************************
    // byte decode at the eighth bit
    // ************************************************************
    eeprom_rd_pkg::dev_state_t state_r;
    eeprom_rd_pkg::dev_state_t after_r;
    eeprom_rd_pkg::dev_state_t next_dec;
    logic [3:0] bitcnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic is_word_r;
    logic mack_r;
    logic oe_r;
    logic ack_dec;
    logic [2:0] quad;
    logic byte_end;
    logic load_tx;
    logic word_ack;

    assign quad = eeprom_rd_pkg::quad_dec(sh_r[3:1]);
    assign byte_end = scl_fall && (state_r == eeprom_rd_pkg::DEV_RX)
        && (bitcnt_r == `BIT_ACK_SLOT);

    always_comb begin
        ack_dec = 1'b0;
        next_dec = eeprom_rd_pkg::DEV_WAIT;
        if (is_word_r) begin
            // write data after the word address is not served here
            ack_dec = 1'b1;
        end else if (sh_r[7:4] == `DEV_TYPE_MEM && sh_r[3:1] == strap_i) begin
            ack_dec = 1'b1;
            next_dec = sh_r[0] ? eeprom_rd_pkg::DEV_TX : eeprom_rd_pkg::DEV_RX;
        end else if (sh_r[7:4] == `DEV_TYPE_QUERY && sh_r[0] && quad[2]) begin
            // straps are not compared for the query
            ack_dec = !protect_i[quad[1:0]];
        end
    end

    assign word_ack = byte_end && is_word_r;
    assign load_tx = scl_fall && (((state_r == eeprom_rd_pkg::DEV_ACK)
        && (after_r == eeprom_rd_pkg::DEV_TX))
        || ((state_r == eeprom_rd_pkg::DEV_RACK) && mack_r));

    // ************************************************************
    // word address counter
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 8'h00;
        end else if (load_tx) begin
            // 8-bit carry drops, so FFh rolls to 00h of the same half
            cnt_r <= cnt_r + 8'h01;
        end else if (word_ack) begin
            cnt_r <= sh_r;
        end
    end

    // ************************************************************
    // link state machine
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= eeprom_rd_pkg::DEV_IDLE;
            after_r <= eeprom_rd_pkg::DEV_IDLE;
            bitcnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            is_word_r <= 1'b0;
            mack_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (start_det) begin
            // a repeated start aborts whatever was going on
            state_r <= eeprom_rd_pkg::DEV_RX;
            bitcnt_r <= 4'h0;
            is_word_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= eeprom_rd_pkg::DEV_IDLE;
            oe_r <= 1'b0;
        end else if (load_tx) begin
            tx_r <= rd_byte;
            oe_r <= !rd_byte[7];
            bitcnt_r <= 4'h0;
            state_r <= eeprom_rd_pkg::DEV_TX;
        end else begin
            case (state_r)
                eeprom_rd_pkg::DEV_RX: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], sda_s};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (byte_end) begin
                        bitcnt_r <= 4'h0;
                        after_r <= next_dec;
                        oe_r <= ack_dec;
                        state_r <= ack_dec ? eeprom_rd_pkg::DEV_ACK
                            : eeprom_rd_pkg::DEV_WAIT;
                    end
                end
                eeprom_rd_pkg::DEV_ACK: begin
                    if (scl_fall) begin
                        oe_r <= 1'b0;
                        state_r <= after_r;
                        is_word_r <= (after_r == eeprom_rd_pkg::DEV_RX);
                    end
                end
                eeprom_rd_pkg::DEV_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_r == `BIT_LAST_TX) begin
                            oe_r <= 1'b0;
                            state_r <= eeprom_rd_pkg::DEV_RACK;
                        end else begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                            tx_r <= {tx_r[6:0], 1'b0};
                            oe_r <= !tx_r[6];
                        end
                    end
                end
                eeprom_rd_pkg::DEV_RACK: begin
                    if (scl_rise) begin
                        mack_r <= !sda_s;
                    end else if (scl_fall) begin
                        // acked case is taken by load_tx above
                        state_r <= eeprom_rd_pkg::DEV_IDLE;
                    end
                end
                eeprom_rd_pkg::DEV_WAIT: begin
                    oe_r <= 1'b0;
                end
                default: begin
                    oe_r <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic sda_o_r;
    logic busy_r;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_o_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;
            busy_r <= (state_r != eeprom_rd_pkg::DEV_IDLE);
        end
    end

    assign bus.dev_sda_o = sda_o_r;
    assign bus.dev_sda_oe = oe_r;
    assign addr_count_o = cnt_r;
    assign busy_o = busy_r;
endmodule

// *** logic/eeprom_mst.sv ***
// bus master end: runs reads and status queries, buffers data in a fifo
`timescale 1ns/100ps
`include "eeprom_rd_consts.svh"
module eeprom_mst (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    eeprom_rd_if.master bus,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [1:0] cmd_kind_i,
    input wire logic [2:0] cmd_strap_i,
    input wire logic [7:0] cmd_word_i,
    input wire logic [7:0] cmd_len_i,
    input wire logic [1:0] cmd_quad_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [7:0] rd_data_o,
    output logic done_o,
    output logic acked_o
);
    localparam logic [3:0] QTR_LAST = 4'(`SCL_QTR_CYC - 1);
    eeprom_rd_pkg::mst_step_t step_r;
    eeprom_rd_pkg::rd_kind_t kind_r;
    logic [2:0] strap_r;
    logic [7:0] word_r;
    logic [7:0] rem_r;
    logic [1:0] quad_r;
    logic [3:0] qcnt_r;
    logic [1:0] ph_r;
    logic [3:0] slot_r;
    logic [7:0] rx_r;
    logic ack_r;
    logic pushed_r;
    logic sda_m;
    logic sda_s;
    logic stall;
    logic tick;
    logic end_op;
    logic tx_step;
    logic fifo_ready;
    logic [7:0] tx_byte;
    logic scl_want;
    logic low_want;

    // ************************************************************
    // data pin synchroniser and bit timing
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= bus.sda;
            sda_s <= sda_m;
        end
    end

    // clock is held low while the fifo is full, stalling the device
    assign stall = (step_r == eeprom_rd_pkg::MST_DATA) && (slot_r == `BIT_ACK_SLOT)
        && (ph_r == 2'h0) && !pushed_r;
    assign tick = (qcnt_r == QTR_LAST) && !stall;
    assign end_op = tick && (ph_r == 2'h3);
    assign tx_step = (step_r == eeprom_rd_pkg::MST_CTRLW) || (step_r == eeprom_rd_pkg::MST_WORD)
        || (step_r == eeprom_rd_pkg::MST_CTRLR);

    always_comb begin
        case (step_r)
            eeprom_rd_pkg::MST_CTRLW: tx_byte = {`DEV_TYPE_MEM, strap_r, 1'b0};
            eeprom_rd_pkg::MST_WORD: tx_byte = word_r;
            default: begin
                if (kind_r == eeprom_rd_pkg::RD_QUERY) begin
                    // query byte carries no strap bits
                    tx_byte = {`DEV_TYPE_QUERY, eeprom_rd_pkg::quad_enc(quad_r), 1'b1};
                end else begin
                    tx_byte = {`DEV_TYPE_MEM, strap_r, 1'b1};
                end
            end
        endcase
    end

    always_comb begin
        scl_want = (ph_r == 2'h1) || (ph_r == 2'h2);
        low_want = 1'b0;
        case (step_r)
            eeprom_rd_pkg::MST_IDLE: scl_want = 1'b1;
            eeprom_rd_pkg::MST_START, eeprom_rd_pkg::MST_RSTART: low_want = ph_r[1];
            eeprom_rd_pkg::MST_STOP: begin
                scl_want = (ph_r != 2'h0);
                low_want = !ph_r[1];
            end
            eeprom_rd_pkg::MST_DATA: begin
                // acknowledge only while bytes remain
                low_want = (slot_r == `BIT_ACK_SLOT) && (rem_r != 8'h00);
            end
            default: low_want = (slot_r != `BIT_ACK_SLOT) && !tx_byte[3'(7 - slot_r)];
        endcase
    end

    // ************************************************************
    // transfer sequencer
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step_r <= eeprom_rd_pkg::MST_IDLE;
            kind_r <= eeprom_rd_pkg::RD_CURRENT;
            strap_r <= 3'h0;
            word_r <= 8'h00;
            rem_r <= 8'h00;
            quad_r <= 2'h0;
            qcnt_r <= 4'h0;
            ph_r <= 2'h0;
            slot_r <= 4'h0;
            rx_r <= 8'h00;
            ack_r <= 1'b0;
            pushed_r <= 1'b0;
            done_o <= 1'b0;
            acked_o <= 1'b0;
            cmd_ready_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            if (step_r == eeprom_rd_pkg::MST_IDLE) begin
                qcnt_r <= 4'h0;
                ph_r <= 2'h0;
                slot_r <= 4'h0;
                if (cmd_valid_i && cmd_ready_o) begin
                    kind_r <= eeprom_rd_pkg::rd_kind_t'(cmd_kind_i);
                    strap_r <= cmd_strap_i;
                    word_r <= cmd_word_i;
                    rem_r <= cmd_len_i;
                    quad_r <= cmd_quad_i;
                    cmd_ready_o <= 1'b0;
                    step_r <= eeprom_rd_pkg::MST_START;
                end
            end else begin
                if (stall && fifo_ready) begin
                    pushed_r <= 1'b1;
                end
                if (!stall) begin
                    qcnt_r <= tick ? 4'h0 : qcnt_r + 4'h1;
                end
                if (tick) begin
                    ph_r <= ph_r + 2'h1;
                end
                if (tick && ph_r == 2'h2 && slot_r == `BIT_ACK_SLOT && tx_step) begin
                    ack_r <= !sda_s;
                end
                if (tick && ph_r == 2'h2 && slot_r != `BIT_ACK_SLOT
                    && step_r == eeprom_rd_pkg::MST_DATA) begin
                    rx_r <= {rx_r[6:0], sda_s};
                end
                if (end_op) begin
                    pushed_r <= 1'b0;
                    slot_r <= 4'h0;
                    case (step_r)
                        eeprom_rd_pkg::MST_START: begin
                            step_r <= (kind_r == eeprom_rd_pkg::RD_RANDOM)
                                ? eeprom_rd_pkg::MST_CTRLW : eeprom_rd_pkg::MST_CTRLR;
                        end
                        eeprom_rd_pkg::MST_RSTART: step_r <= eeprom_rd_pkg::MST_CTRLR;
                        eeprom_rd_pkg::MST_STOP: begin
                            step_r <= eeprom_rd_pkg::MST_IDLE;
                            done_o <= 1'b1;
                            cmd_ready_o <= 1'b1;
                        end
                        default: begin
                            if (slot_r != `BIT_ACK_SLOT) begin
                                slot_r <= slot_r + 4'h1;
                            end else if (step_r == eeprom_rd_pkg::MST_DATA) begin
                                rem_r <= rem_r - 8'h01;
                                if (rem_r == 8'h00) begin
                                    step_r <= eeprom_rd_pkg::MST_STOP;
                                end
                            end else begin
                                acked_o <= ack_r;
                                if (!ack_r || (step_r == eeprom_rd_pkg::MST_CTRLR
                                    && kind_r == eeprom_rd_pkg::RD_QUERY)) begin
                                    step_r <= eeprom_rd_pkg::MST_STOP;
                                end else if (step_r == eeprom_rd_pkg::MST_CTRLW) begin
                                    step_r <= eeprom_rd_pkg::MST_WORD;
                                end else if (step_r == eeprom_rd_pkg::MST_WORD) begin
                                    step_r <= eeprom_rd_pkg::MST_RSTART;
                                end else begin
                                    step_r <= eeprom_rd_pkg::MST_DATA;
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // pin registers and read buffer
    // ************************************************************
    logic scl_r;
    logic oe_r;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_r <= 1'b1;
            oe_r <= 1'b0;
        end else begin
            scl_r <= scl_want;
            oe_r <= low_want;
        end
    end

    assign bus.mst_scl_o = scl_r;
    assign bus.mst_sda_o = 1'b0;
    assign bus.mst_sda_oe = oe_r;

    rd_fifo #(
        .WIDTH(`RD_FIFO_WIDTH),
        .DEPTH(`RD_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(stall),
        .in_ready_o(fifo_ready),
        .in_data_i(rx_r),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o)
    );
endmodule

// *** dv/eeprom_rd_assertions.sv ***
// link-level checks of the serial read path between both ends
`timescale 1ns/100ps
module eeprom_rd_assertions (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ************
    // wire timing
    // ************
    scl_high_wide_a: assert property ($rose(scl) |-> scl[*8]) else $error("scl high short");
    scl_low_wide_a: assert property ($fell(scl) |-> !scl[*4]) else $error("scl low short");
    // device may only move data while the clock is low
    dev_edge_low_a: assert property ($changed(dev_sda_oe) |-> !scl) else $error("dev moved");
    dev_fall_hold_a: assert property ($fell(scl) |-> $stable(dev_sda_oe)) else $error("no hold");
    start_dev_off_a: assert property (scl && $fell(sda) |-> !dev_sda_oe) else $error("start");
    stop_release_a: assert property (scl && $rose(sda) |-> !dev_sda_oe[*4]) else $error("held");
    stop_idle_a: assert property (scl && $rose(sda) |-> scl[*4]) else $error("not idle");
    dev_pull_low_a: assert property (dev_sda_oe |-> !dev_sda_o) else $error("dev drove high");
    cover property ($rose(dev_sda_oe));
    cover property (scl && $rose(sda));
    cover property (scl && $fell(sda));
endmodule

// *** dv/tb_eeprom_serial_read_path.sv ***
// self-checking bench joining both ends of the serial read link
`timescale 1ns/100ps
module tb_eeprom_serial_read_path;
    logic core_clk_i = 0, nrst_i = 0, vld = 0, rdy = 0, done, ack, rv, ld = 0, half = 0, stall = 0;
    logic busy;
    logic [1:0] kind = 0, quad = 0;
    logic [2:0] strap = 3'h5, cs = 3'h5;
    logic [3:0] prot = 0;
    logic [7:0] word = 0, len = 0, rdat, cnt, mem [512], q [$];
    logic [8:0] la = 0;
    integer seed = 32'h36088AAB, fail_count = 0, tests_run = 0, cyc = 0;
    eeprom_rd_if bus();
    eeprom_dev u_eeprom_dev (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus(bus), .strap_i(strap),
        .half_sel_i(half), .protect_i(prot), .load_en_i(ld), .load_addr_i(la),
        .load_data_i(mem[la]), .addr_count_o(cnt), .busy_o(busy));
    eeprom_mst u_eeprom_mst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus(bus), .cmd_valid_i(vld),
        .cmd_ready_o(), .cmd_kind_i(kind), .cmd_strap_i(cs), .cmd_word_i(word), .cmd_len_i(len),
        .cmd_quad_i(quad), .rd_valid_o(rv), .rd_ready_i(rdy), .rd_data_o(rdat), .done_o(done),
        .acked_o(ack));
    eeprom_rd_assertions u_eeprom_rd_assertions (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .scl(bus.scl), .sda(bus.sda), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("counts: run %0d fail %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // expected bytes wrap inside the selected half
    task automatic run(input logic [1:0] k, input logic [7:0] w, input logic [7:0] l, input bit e);
        int n;
        n = 0;
        for (int i = 0; e && i <= l; i++) q.push_back(mem[{half, 8'(w + i)}]);
        kind = k;
        word = w;
        len = l;
        vld = 1;
        @(negedge core_clk_i) vld = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 20000) begin
            fail_count++;
            end_of_test();
        end
        $display("test kind %0d done", k);
    endtask
    always @(negedge core_clk_i) rdy <= !stall && ($random(seed) % 4 != 0);
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            end_of_test();
        end
        if (nrst_i && rv && rdy) check(rdat, q.size() ? q.pop_front() : ~rdat);
    end
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = $random(seed);
        repeat (10) @(negedge core_clk_i);
        nrst_i = 1;
        ld = 1;
        for (int i = 0; i < 512; i++) begin
            la = 9'(i);
            @(negedge core_clk_i);
        end
        ld = 0;
        run(eeprom_rd_pkg::RD_RANDOM, 8'hFE, 8'h03, 1);
        check(ack, 1'b1);
        check(cnt, 8'h02);
        // current read starts where the random read left the counter
        run(eeprom_rd_pkg::RD_CURRENT, 8'h02, 8'h00, 1);
        check(cnt, 8'h03);
        half = 1;
        run(eeprom_rd_pkg::RD_CURRENT, 8'h03, 8'h01, 1);
        check(cnt, 8'h05);
        prot = $random(seed);
        for (int i = 0; i < 4; i++) begin
            quad = 2'(i);
            run(eeprom_rd_pkg::RD_QUERY, 8'h00, 8'h00, 0);
            check(ack, !prot[i]);
        end
        cs = ~strap;
        run(eeprom_rd_pkg::RD_CURRENT, 8'h00, 8'h00, 0);
        check(ack, 1'b0);
        cs = strap;
        // far side stalls so the buffer fills and the master stretches the clock
        stall = 1;
        fork
            begin
                repeat (6000) @(negedge core_clk_i);
                stall = 0;
            end
        join_none
        run(eeprom_rd_pkg::RD_CURRENT, 8'h05, 8'h27, 1);
        check(cnt, 8'h2D);
        repeat (300) @(negedge core_clk_i);
        check(8'(q.size()), 8'h00);
        check(8'(busy), 8'h00);
        end_of_test();
    end
endmodule
